// ===== hw/cpu_timing_params.svh
// Offsets, field positions, reset values and timing counts of the timing block
`ifndef CPU_TIMING_PARAMS_SVH
`define CPU_TIMING_PARAMS_SVH

// Oscillator clocks per machine cycle and per timer tick
`define CLK_PER_MC_NORMAL 11'h004
`define CLK_PER_MC_REDUCED 11'h400
`define CYC_LAST_NORMAL 10'h003
`define CYC_LAST_REDUCED 10'h3FF
`define TICK_LAST_SLOW 4'hB
`define TICK_LAST_FAST 4'h3
`define TICK_LEN_SLOW 4'hC
`define TICK_LEN_FAST 4'h4

// Register offsets
`define REG_CTRL 8'h00
`define REG_POWER 8'h01
`define REG_STATUS 8'h02
`define REG_PTR_SEL 8'h03
`define REG_PTR_AUTO 8'h04
`define REG_SP_LO 8'h05
`define REG_SP_HI 8'h06
`define REG_PTR_BASE 8'h08
`define PTR_STRIDE 8'h03

// Control register fields
`define CTRL_RR_REQ 0
`define CTRL_SWITCHBACK 1
`define CTRL_TIMER_FAST 2
`define CTRL_SP_WIDE 3
`define CTRL_DEMUX 4
`define CTRL_AMODE_LO 5
`define CTRL_AMODE_HI 6
`define CTRL_PF_RST_EN 7
`define CTRL_RESET 8'h00

// Power, status and pointer select fields
`define POWER_IDLE 0
`define POWER_STOP 1
`define STATUS_PF_WARN 0
`define STATUS_RR_ACTIVE 1
`define STATUS_BUSY 2
`define PTRSEL_TOGGLE 2

// Strap capture delay after reset release
`define STRAP_CAPTURE 2'h2

`endif

// ===== hw/cpu_timing_pkg.sv
// Types shared by the machine-cycle timing block
package cpu_timing_pkg;
    typedef enum logic [1:0] {
        AMODE_16 = 2'h0,
        AMODE_PAGED = 2'h1,
        AMODE_CONTIG = 2'h2
    } addr_mode_e;

    typedef enum logic [2:0] {
        IC_ONE = 3'h0,
        IC_PTR_INC = 3'h1,
        IC_EXT_READ = 3'h2,
        IC_MOV_DD = 3'h3,
        IC_FOUR = 3'h4,
        IC_FIVE = 3'h5
    } instr_class_e;

    typedef enum logic [1:0] {
        ST_READY = 2'b01,
        ST_EXEC = 2'b10
    } seq_state_e;
endpackage

// ===== hw/cpu_machine_cycle_timing.sv
// Machine-cycle timing, power modes, data pointers and stack width control
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "cpu_timing_params.svh"

// Function
// - Normal machine cycle lasts four oscillator clocks.
// - Reduced-rate mode stretches machine cycle to 1024 clocks.
// - With switchback on, interrupt or serial activity leaves reduced-rate mode.
// - Timers advance every twelve clocks after reset.
// - Fast timer setting advances timers every four clocks.
// - One address-latch strobe pulse per machine cycle.
// - External data read through pointer takes two machine cycles.
// - Direct-to-direct move takes three machine cycles.
// - Pointer increment completes in one machine cycle.
// - Instructions take one to five machine cycles, never more.
// - Instructions affect flags exactly as legacy; only timing differs.
// - Stack pointer selectable 8 or 10 bits, reaching 1kB.
// - 16-bit, 24-bit paged and 24-bit contiguous address modes.
// - ROM disabled means power-up in 16-bit memory mode.
// - Each of four pointers may auto increment or decrement.
// - Automatic toggle between pointers for block moves.
// - Optional internal demultiplex of data and low address byte.
// - Falling supply raises warning interrupt and may force reset.
// - Software may place processor in idle or stop.
module cpu_machine_cycle_timing (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // Instruction sequencing
    input wire logic instr_start_in,
    input wire logic [2:0] instr_class_in,
    output logic instr_ready_out,
    output logic instr_done_out,
    // Pins from outside the clock domain
    input wire logic ext_int_in,
    input wire logic serial_act_in,
    input wire logic pf_warn_in,
    input wire logic pf_crit_in,
    input wire logic rom_disable_in,
    // Timing strobes
    output logic ale_out,
    output logic mc_end_out,
    output logic timer_tick_out,
    // Status and configuration outputs
    output logic pf_irq_out,
    output logic pf_reset_out,
    output logic idle_out,
    output logic stop_out,
    output logic [1:0] addr_mode_out,
    output logic demux_out,
    output logic sp_wide_out,
    output logic [9:0] stack_ptr_out,
    output logic [1:0] ptr_sel_out,
    output logic [23:0] ptr_value_out
);

    // Machine cycles per instruction class
    function automatic logic [2:0] cycles_of(input logic [2:0] cls);
        case (cls)
            cpu_timing_pkg::IC_ONE: cycles_of = 3'h1;
            cpu_timing_pkg::IC_PTR_INC: cycles_of = 3'h1;
            cpu_timing_pkg::IC_EXT_READ: cycles_of = 3'h2;
            cpu_timing_pkg::IC_MOV_DD: cycles_of = 3'h3;
            cpu_timing_pkg::IC_FOUR: cycles_of = 3'h4;
            cpu_timing_pkg::IC_FIVE: cycles_of = 3'h5;
            default: cycles_of = 3'h1;
        endcase
    endfunction

    // Register byte address of pointer i, byte j
    function automatic logic ptr_hit(input logic [7:0] a, input int i, input int j);
        ptr_hit = (a == 8'(`REG_PTR_BASE + i * `PTR_STRIDE + j));
    endfunction

    logic [7:0] ctrl;
    logic rr_active;
    logic idle_q;
    logic stop_q;
    logic pf_flag;
    logic [1:0] ptr_sel;
    logic ptr_toggle_en;
    logic [7:0] ptr_auto;
    logic [9:0] stack_ptr;
    logic [9:0] cyc_cnt;
    logic [3:0] tick_cnt;
    logic [2:0] cyc_left;
    logic [2:0] exec_class;
    logic [23:0] ptr_q [4];
    cpu_timing_pkg::seq_state_e state;
    logic [4:0] sync_a;
    logic [4:0] sync_b;
    logic int_prev;
    logic ser_prev;
    logic [1:0] strap_cnt;
    logic running;
    logic cyc_end;
    logic wake_evt;
    logic accept;
    logic ptr_step;
    logic ptr_dec;
    logic wr_ctrl;

    // Two-stage synchronisers; only sync_b is read by logic
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            sync_a <= 5'h00;
            sync_b <= 5'h00;
        end else begin
            sync_a <= {rom_disable_in, pf_crit_in, pf_warn_in, serial_act_in, ext_int_in};
            sync_b <= sync_a;
        end
    end

    // Edge history for wake events
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            int_prev <= 1'b0;
            ser_prev <= 1'b0;
        end else begin
            int_prev <= sync_b[0];
            ser_prev <= sync_b[1];
        end
    end

    assign wake_evt = (sync_b[0] && !int_prev) || (sync_b[1] && !ser_prev);
    assign wr_ctrl = reg_wr_in && (reg_addr_in == `REG_CTRL);

    // Machine cycle counter; frozen in stop, idle keeps it running
    assign running = !stop_q;
    assign cyc_end = running && (cyc_cnt == (rr_active ? `CYC_LAST_REDUCED
                                                        : `CYC_LAST_NORMAL));
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            cyc_cnt <= 10'h000;
        end else if (cyc_end) begin
            cyc_cnt <= 10'h000;
        end else if (running) begin
            cyc_cnt <= cyc_cnt + 10'h001;
        end
    end

    // Cycle length follows the request only at a boundary, never mid-cycle
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            rr_active <= 1'b0;
        end else if (cyc_end) begin
            rr_active <= ctrl[`CTRL_RR_REQ];
        end
    end

    // Strobes: one latch pulse in the first clock of every cycle
    assign ale_out = running && (cyc_cnt == 10'h000);
    assign mc_end_out = cyc_end;

    // Control register, switchback and ROM strap
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            ctrl <= `CTRL_RESET;
            strap_cnt <= 2'h0;
        end else begin
            if (strap_cnt != 2'h3) begin
                strap_cnt <= strap_cnt + 2'h1;
            end
            if (wr_ctrl) begin
                ctrl <= reg_wdata_in;
            end else if (strap_cnt == `STRAP_CAPTURE && !sync_b[4]) begin
                // ROM firmware expects the flat map; ROM off stays 16-bit
                ctrl[`CTRL_AMODE_HI:`CTRL_AMODE_LO] <= cpu_timing_pkg::AMODE_CONTIG;
            end else if (ctrl[`CTRL_SWITCHBACK] && rr_active && wake_evt) begin
                ctrl[`CTRL_RR_REQ] <= 1'b0;
            end
        end
    end

    // Idle and stop; an external interrupt wakes from either
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            idle_q <= 1'b0;
            stop_q <= 1'b0;
        end else if (sync_b[0] && !int_prev) begin
            idle_q <= 1'b0;
            stop_q <= 1'b0;
        end else if (reg_wr_in && reg_addr_in == `REG_POWER) begin
            idle_q <= idle_q | reg_wdata_in[`POWER_IDLE];
            stop_q <= stop_q | reg_wdata_in[`POWER_STOP];
        end
    end

    // Timer prescaler: 12 clocks by default, 4 when fast
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            tick_cnt <= 4'h0;
            timer_tick_out <= 1'b0;
        end else if (!running) begin
            timer_tick_out <= 1'b0;
        end else if (tick_cnt >= (ctrl[`CTRL_TIMER_FAST] ? `TICK_LAST_FAST
                                                         : `TICK_LAST_SLOW)) begin
            tick_cnt <= 4'h0;
            timer_tick_out <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 4'h1;
            timer_tick_out <= 1'b0;
        end
    end

    // Instruction sequencer; flags are the datapath's, untouched here
    assign instr_ready_out = (state == cpu_timing_pkg::ST_READY) && ale_out && !idle_q;
    assign accept = instr_start_in && instr_ready_out;
    assign instr_done_out = (state == cpu_timing_pkg::ST_EXEC) && cyc_end
                            && (cyc_left == 3'h1);
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            state <= cpu_timing_pkg::ST_READY;
            cyc_left <= 3'h0;
            exec_class <= 3'h0;
        end else begin
            case (state)
                cpu_timing_pkg::ST_READY: begin
                    if (accept) begin
                        state <= cpu_timing_pkg::ST_EXEC;
                        cyc_left <= cycles_of(instr_class_in);
                        exec_class <= instr_class_in;
                    end
                end
                cpu_timing_pkg::ST_EXEC: begin
                    if (instr_done_out) begin
                        state <= cpu_timing_pkg::ST_READY;
                    end else if (cyc_end) begin
                        cyc_left <= cyc_left - 3'h1;
                    end
                end
                default: state <= cpu_timing_pkg::ST_READY;
            endcase
        end
    end

    // Pointer stepping at the end of pointer-related instructions
    assign ptr_step = instr_done_out && ((exec_class == cpu_timing_pkg::IC_PTR_INC)
                      || (exec_class == cpu_timing_pkg::IC_EXT_READ
                          && ptr_auto[ptr_sel]));
    assign ptr_dec = (exec_class == cpu_timing_pkg::IC_EXT_READ) && ptr_auto[4 + ptr_sel];

    // Four data pointers; 16-bit mode wraps within 64kB
    for (genvar gi = 0; gi < 4; gi++) begin : g_ptr
        always_ff @(posedge clk_sys_in) begin
            if (!rst_n_in) begin
                ptr_q[gi] <= 24'h000000;
            end else if (reg_wr_in && ptr_hit(reg_addr_in, gi, 0)) begin
                ptr_q[gi][7:0] <= reg_wdata_in;
            end else if (reg_wr_in && ptr_hit(reg_addr_in, gi, 1)) begin
                ptr_q[gi][15:8] <= reg_wdata_in;
            end else if (reg_wr_in && ptr_hit(reg_addr_in, gi, 2)) begin
                ptr_q[gi][23:16] <= reg_wdata_in;
            end else if (ptr_step && ptr_sel == 2'(gi)) begin
                if (addr_mode_out == cpu_timing_pkg::AMODE_16) begin
                    ptr_q[gi][15:0] <= ptr_dec ? ptr_q[gi][15:0] - 16'h0001
                                               : ptr_q[gi][15:0] + 16'h0001;
                end else begin
                    ptr_q[gi] <= ptr_dec ? ptr_q[gi] - 24'h000001
                                         : ptr_q[gi] + 24'h000001;
                end
            end
        end
    end

    // Pointer select with automatic toggle after external reads
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            ptr_sel <= 2'h0;
            ptr_toggle_en <= 1'b0;
            ptr_auto <= 8'h00;
        end else begin
            if (reg_wr_in && reg_addr_in == `REG_PTR_SEL) begin
                ptr_sel <= reg_wdata_in[1:0];
                ptr_toggle_en <= reg_wdata_in[`PTRSEL_TOGGLE];
            end else if (instr_done_out && ptr_toggle_en
                         && exec_class == cpu_timing_pkg::IC_EXT_READ) begin
                ptr_sel[0] <= ~ptr_sel[0];
            end
            if (reg_wr_in && reg_addr_in == `REG_PTR_AUTO) begin
                ptr_auto <= reg_wdata_in;
            end
        end
    end

    // Stack pointer; upper bits held at zero in 8-bit form
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            stack_ptr <= 10'h007;
        end else if (reg_wr_in && reg_addr_in == `REG_SP_LO) begin
            stack_ptr[7:0] <= reg_wdata_in;
        end else if (reg_wr_in && reg_addr_in == `REG_SP_HI && ctrl[`CTRL_SP_WIDE]) begin
            stack_ptr[9:8] <= reg_wdata_in[1:0];
        end else if (!ctrl[`CTRL_SP_WIDE]) begin
            stack_ptr[9:8] <= 2'h0;
        end
    end

    // Power-fail: sticky warning, set wins over write-one-to-clear
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            pf_flag <= 1'b0;
            pf_reset_out <= 1'b0;
        end else begin
            if (sync_b[2]) begin
                pf_flag <= 1'b1;
            end else if (reg_wr_in && reg_addr_in == `REG_STATUS
                         && reg_wdata_in[`STATUS_PF_WARN]) begin
                pf_flag <= 1'b0;
            end
            pf_reset_out <= sync_b[3] && ctrl[`CTRL_PF_RST_EN];
        end
    end

    // Read data, one cycle after the read strobe; unmapped reads zero
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            reg_rdata_out <= 8'h00;
            case (reg_addr_in)
                `REG_CTRL: reg_rdata_out <= ctrl;
                `REG_POWER: reg_rdata_out <= {6'h00, stop_q, idle_q};
                `REG_STATUS: reg_rdata_out <= {5'h00, state == cpu_timing_pkg::ST_EXEC,
                                               rr_active, pf_flag};
                `REG_PTR_SEL: reg_rdata_out <= {5'h00, ptr_toggle_en, ptr_sel};
                `REG_PTR_AUTO: reg_rdata_out <= ptr_auto;
                `REG_SP_LO: reg_rdata_out <= stack_ptr[7:0];
                `REG_SP_HI: reg_rdata_out <= {6'h00, stack_ptr[9:8]};
                default: begin
                    for (int i = 0; i < 4; i++) begin
                        if (ptr_hit(reg_addr_in, i, 0)) reg_rdata_out <= ptr_q[i][7:0];
                        if (ptr_hit(reg_addr_in, i, 1)) reg_rdata_out <= ptr_q[i][15:8];
                        if (ptr_hit(reg_addr_in, i, 2)) reg_rdata_out <= ptr_q[i][23:16];
                    end
                end
            endcase
        end
    end

    // Output views of state
    assign pf_irq_out = pf_flag;
    assign idle_out = idle_q;
    assign stop_out = stop_q;
    assign addr_mode_out = ctrl[`CTRL_AMODE_HI:`CTRL_AMODE_LO];
    assign demux_out = ctrl[`CTRL_DEMUX];
    assign sp_wide_out = ctrl[`CTRL_SP_WIDE];
    assign stack_ptr_out = stack_ptr;
    assign ptr_sel_out = ptr_sel;
    assign ptr_value_out = ptr_q[ptr_sel];

    // Checking helpers: clocks per cycle, latch pulses, ticks
    logic [10:0] run_len;
    logic [1:0] ale_seen;
    logic [3:0] tick_gap;
    logic fast_moved;
    logic [10:0] sb_wait;
    // Clocks spent in a long cycle after the request dropped; bounds the switchback
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            sb_wait <= 11'h000;
        end else if (rr_active && !ctrl[`CTRL_RR_REQ] && running) begin
            sb_wait <= (sb_wait == 11'h7FF) ? sb_wait : sb_wait + 11'h001;
        end else if (!rr_active || ctrl[`CTRL_RR_REQ]) begin
            sb_wait <= 11'h000;
        end
    end
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            run_len <= 11'h000;
            ale_seen <= 2'h0;
            tick_gap <= 4'h0;
            fast_moved <= 1'b1;
        end else begin
            if (cyc_end) run_len <= 11'h000;
            else if (running) run_len <= run_len + 11'h001;
            if (cyc_end) ale_seen <= 2'h0;
            else if (ale_out && ale_seen != 2'h3) ale_seen <= ale_seen + 2'h1;
            if (timer_tick_out) tick_gap <= 4'h1;
            else if (running && tick_gap != 4'hF) tick_gap <= tick_gap + 4'h1;
            if (timer_tick_out) fast_moved <= 1'b0;
            else if (wr_ctrl || !running) fast_moved <= 1'b1;
        end
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    a_cycle_len_normal: assert property (cyc_end && !rr_active |->
        run_len == `CLK_PER_MC_NORMAL - 11'h001) else $error("cycle not 4 clocks");
    a_cycle_len_reduced: assert property (cyc_end && rr_active |->
        run_len == `CLK_PER_MC_REDUCED - 11'h001) else $error("cycle not 1024");
    a_switchback_exit: assert property (ctrl[`CTRL_SWITCHBACK] && rr_active && wake_evt
        && !wr_ctrl && strap_cnt == 2'h3 && !stop_q |=> !ctrl[`CTRL_RR_REQ])
        else $error("no switchback");
    a_switchback_bound: assert property (sb_wait <= `CLK_PER_MC_REDUCED)
        else $error("reduced rate held past boundary");
    a_tick_slow: assert property (timer_tick_out && !ctrl[`CTRL_TIMER_FAST] && !fast_moved
        |-> tick_gap == `TICK_LEN_SLOW) else $error("tick not 12");
    a_tick_fast: assert property (timer_tick_out && ctrl[`CTRL_TIMER_FAST] && !fast_moved
        |-> tick_gap == `TICK_LEN_FAST) else $error("tick not 4");
    a_one_ale: assert property (cyc_end |-> ale_seen == 2'h1)
        else $error("latch pulses per cycle wrong");
    a_ext_read_len: assert property (accept && instr_class_in == cpu_timing_pkg::IC_EXT_READ
        && !rr_active && !ctrl[`CTRL_RR_REQ] ##1 !stop_q[*7] |-> instr_done_out)
        else $error("read not 8 clocks");
    a_move_len: assert property (accept && instr_class_in == cpu_timing_pkg::IC_MOV_DD
        && !rr_active && !ctrl[`CTRL_RR_REQ] && !stop_q ##1 (!stop_q && !wr_ctrl)[*8]
        |-> ##3 instr_done_out) else $error("move not 12 clocks");
    a_ptr_inc_len: assert property (accept && instr_class_in == cpu_timing_pkg::IC_PTR_INC
        && !rr_active && !stop_q ##1 !stop_q[*3] |-> instr_done_out)
        else $error("increment not one cycle");
    a_ptr_auto_inc: assert property (ptr_step && !ptr_dec && !reg_wr_in
        && addr_mode_out != cpu_timing_pkg::AMODE_16 |=>
        ptr_q[$past(ptr_sel)] == $past(ptr_value_out) + 24'h000001)
        else $error("pointer not stepped");
    a_ptr_toggle: assert property (instr_done_out && ptr_toggle_en && !reg_wr_in
        && exec_class == cpu_timing_pkg::IC_EXT_READ |=> ptr_sel[0] != $past(ptr_sel[0]))
        else $error("pointer select not toggled");
    a_sp_narrow: assert property (!sp_wide_out ##1 !sp_wide_out |-> stack_ptr_out[9:8] == 2'h0)
        else $error("stack exceeds 8 bits");
    a_rom_off_16: assert property (strap_cnt == 2'h3 && $past(strap_cnt) == `STRAP_CAPTURE
        && $past(sync_b[4]) && !$past(wr_ctrl) |-> addr_mode_out == $past(addr_mode_out))
        else $error("ROM off left 16-bit mode");
    a_pf_warn: assert property ($rose(pf_warn_in) ##1 pf_warn_in[*2] |-> ##[0:1] pf_irq_out)
        else $error("power-fail warning lost");
    a_idle_holds: assert property (idle_q |-> !instr_ready_out)
        else $error("issue during idle");
    a_stop_freezes: assert property (stop_q ##1 stop_q |-> $stable(cyc_cnt))
        else $error("cycle ran in stop");
    a_mode_boundary: assert property ($changed(rr_active) |-> $past(cyc_end))
        else $error("cycle length changed mid-cycle");

    c_reduced_mode: cover property (rr_active && cyc_end);
    c_switchback: cover property ($fell(rr_active));
    c_ext_read_done: cover property (instr_done_out && exec_class == cpu_timing_pkg::IC_EXT_READ);
    c_stop_wake: cover property ($fell(stop_q));

endmodule // cpu_machine_cycle_timing
`default_nettype wire

// ===== sim/ext_mem_model.sv
// External memory side: latches one address per strobe pulse
`timescale 1ns/100ps
`default_nettype none
module ext_mem_model (
    // Strobes from the device
    input wire logic clk_in,
    input wire logic ale_in,
    // Count of latched addresses
    output logic [15:0] ale_count_out
);
    // One latch per strobe clock; the count is all the bench needs
    initial ale_count_out = 16'h0000;
    always_ff @(posedge clk_in) begin
        if (ale_in) ale_count_out <= ale_count_out + 16'h0001;
    end
endmodule // ext_mem_model
`default_nettype wire

// ===== sim/cpu_machine_cycle_timing_bench.sv
// Self-checking bench for the machine-cycle timing block
`timescale 1ns/100ps
`default_nettype none
module cpu_machine_cycle_timing_bench;
    logic clk, rst_n, wr, rd, start, eint, sact, pfw, pfc, romd, rd_dly;
    logic ready, done, ale, mce, tick, pfirq, pfrst, idle, stop, demux, spw;
    logic [7:0] addr, wdata, rdata;
    logic [2:0] cls;
    logic [1:0] amode, psel;
    logic [9:0] sp;
    logic [23:0] pv, v;
    logic [15:0] nale, a0;
    logic [7:0] exp_q[$];
    int n_fail, compares, n;

    cpu_machine_cycle_timing dut_u (.clk_sys_in(clk), .rst_n_in(rst_n),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .instr_start_in(start), .instr_class_in(cls),
        .instr_ready_out(ready), .instr_done_out(done), .ext_int_in(eint),
        .serial_act_in(sact), .pf_warn_in(pfw), .pf_crit_in(pfc),
        .rom_disable_in(romd), .ale_out(ale), .mc_end_out(mce), .timer_tick_out(tick),
        .pf_irq_out(pfirq), .pf_reset_out(pfrst), .idle_out(idle), .stop_out(stop),
        .addr_mode_out(amode), .demux_out(demux), .sp_wide_out(spw),
        .stack_ptr_out(sp), .ptr_sel_out(psel), .ptr_value_out(pv));
    ext_mem_model mem_u (.clk_in(clk), .ale_in(ale), .ale_count_out(nale));

    // 200 MHz oscillator
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] e);
        compares++;
        if (seen !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, seen);
        end
    endtask

    task test_done();
        if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Register cycles; settle on the falling edge so outputs have landed
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        @(negedge clk);
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
    endtask

    // Read data land in the cycle after the strobe and hold until the next read
    always @(posedge clk) rd_dly <= rd;
    always @(negedge clk) if (rd_dly === 1'b1) chk("rdata", {16'h0000, rdata}, exp_q.pop_front());

    // Clocks from one strobe (0 latch, 1 timer) to the next
    task automatic gap(input int s, output int g);
        g = 0;
        @(negedge clk);
        while ((s == 0 ? ale : tick) !== 1'b1) @(negedge clk);
        do begin
            @(negedge clk);
            g++;
        end while ((s == 0 ? ale : tick) !== 1'b1 && g < 2000);
    endtask

    task automatic run(input logic [2:0] c, input int cyc);
        @(posedge clk);
        start <= 1'b1; cls <= c;
        do @(negedge clk); while (ready !== 1'b1);
        a0 = nale;
        @(posedge clk);
        start <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (done !== 1'b1 && n < 100);
        chk("instr clocks", n[23:0], 24'(4 * cyc - 1));
        chk("latch per instr", {8'h00, nale - a0}, 24'(cyc));
    endtask

    // Pin pulse long enough to pass the synchronisers
    task automatic pulse(input bit s);
        @(posedge clk);
        if (s) sact <= 1'b1;
        else eint <= 1'b1;
        repeat (4) @(posedge clk);
        sact <= 1'b0; eint <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    // Main sequence
    initial begin
        {wr, rd, start, eint, sact, pfw, pfc} = 7'h00;
        addr = 8'h00; wdata = 8'h00; cls = 3'h0; romd = 1'b1; rst_n = 1'b0;
        n_fail = 0; compares = 0;
        v = $urandom(98012);
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (10) @(posedge clk);
        chk("addr mode", amode, 2'h0);
        rd_reg(8'h05, 8'h07);
        rd_reg(8'hFF, 8'h00);
        gap(0, n); chk("mc clocks", n[23:0], 24'h4);
        gap(1, n); chk("tick slow", n[23:0], 24'hC);
        wr_reg(8'h00, 8'h04); gap(1, n); gap(1, n); chk("tick fast", n[23:0], 24'h4);
        for (int i = 0; i < 3; i++) begin
            wr_reg(8'h00, {1'b0, 2'(i), 5'h10});
            chk("mode", {amode, demux}, 24'(i * 2 + 1));
        end
        // Pointer 0 with a random start, contiguous mode
        wr_reg(8'h00, 8'h40);
        v = 24'($urandom);
        for (int j = 0; j < 3; j++) wr_reg(8'(8 + j), v[j*8 +: 8]);
        rd_reg(8'h09, v[15:8]);
        run(3'h1, 1); @(negedge clk); chk("ptr inc", pv, v + 24'h1);
        wr_reg(8'h04, 8'h11); wr_reg(8'h03, 8'h04);
        run(3'h2, 2); @(negedge clk); chk("ptr sel", psel, 2'h1);
        wr_reg(8'h03, 8'h00); chk("ptr dec", pv, v);
        run(3'h3, 3);
        for (int k = 0; k < 3; k++) run(3'(k == 0 ? 0 : k + 3), k == 0 ? 1 : k + 3);
        for (int i = 0; i < 2; i++) begin
            wr_reg(8'h01, 8'(i + 1));
            chk("power state", {stop, idle, ready}, 24'((i + 1) * 2));
            pulse(0);
            rd_reg(8'h01, 8'h00);
        end
        for (int i = 0; i < 2; i++) begin
            wr_reg(8'h00, 8'h03); gap(0, n); gap(0, n);
            chk("slow mc", n[23:0], 24'h400);
            rd_reg(8'h02, 8'h02);
            pulse(i[0]); gap(0, n); gap(0, n);
            chk("switchback mc", n[23:0], 24'h4);
        end
        @(posedge clk); pfw <= 1'b1;
        repeat (4) @(posedge clk); pfw <= 1'b0;
        @(negedge clk); chk("pf flag", pfirq, 1'b1);
        rd_reg(8'h02, 8'h01); wr_reg(8'h02, 8'h01); rd_reg(8'h02, 8'h00);
        wr_reg(8'h00, 8'h80); pfc <= 1'b1;
        repeat (5) @(negedge clk); chk("pf reset", pfrst, 1'b1);
        pfc <= 1'b0;
        wr_reg(8'h06, 8'h03); rd_reg(8'h06, 8'h00);
        wr_reg(8'h00, 8'h08); wr_reg(8'h06, 8'h03); rd_reg(8'h06, 8'h03);
        chk("sp high", {spw, sp[9:8]}, 24'h7);
        test_done();
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        test_done();
    end
endmodule // cpu_machine_cycle_timing_bench
`default_nettype wire
